// ===== epwm_load.sv
`timescale 1ns/10ps
module epwm_load (
   input  wire logic [3:0] i_pwm_out,
   input  wire logic [3:0] i_pwm_oe_n,
   output logic      [3:0] o_level
);
   // ************************************************
   // switch driver inputs
   // ************************************************
   // a released pin falls to the pull-down, so its switch stays off
   assign o_level = i_pwm_out & ~i_pwm_oe_n;
endmodule

// ===== epwm_pkg.sv
package epwm_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam int           ADDR_W      = 5;
   localparam logic [4:0]   ADDR_CTRL   = 5'h00;
   localparam logic [4:0]   ADDR_DUTY   = 5'h04;
   localparam logic [4:0]   ADDR_PERIOD = 5'h08;
   localparam logic [4:0]   ADDR_TCTRL  = 5'h0c;
   localparam logic [4:0]   ADDR_FLAGS  = 5'h10;
   localparam logic [4:0]   ADDR_DIR    = 5'h14;
   localparam logic [4:0]   ADDR_TIMER  = 5'h18;

   // ***********************************************************
   // fields and reset values
   // ***********************************************************
   typedef enum logic [1:0] {
      EPWM_SINGLE,
      EPWM_HALF,
      EPWM_FWD,
      EPWM_REV
   } epwm_cfg_t;

   typedef struct packed {
      epwm_cfg_t  cfg;
      logic [1:0] duty_lo;
      logic [1:0] msel_hi;
      logic       pol_ac_low;
      logic       pol_bd_low;
   } epwm_ctrl_t;

   typedef struct packed {
      logic [4:0] rsvd;
      logic       run;
      logic [1:0] pre;
   } epwm_tctrl_t;

   localparam logic [1:0] MSEL_PWM    = 2'b11;
   localparam int         FLAG_BIT    = 0;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] DUTY_RST    = 8'h00;
   localparam logic [7:0] PERIOD_RST  = 8'hff;
   localparam logic [7:0] TCTRL_RST   = 8'h00;
   localparam logic [3:0] DIR_RST     = 4'hf;
   localparam logic [1:0] FINE_LAST   = 2'h3;
   localparam logic [3:0] PRE_DIV1    = 4'h0;
   localparam logic [3:0] PRE_DIV4    = 4'h3;
   localparam logic [3:0] PRE_DIV16   = 4'hf;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] USE_SINGLE  = 4'h1;
   localparam logic [3:0] USE_HALF    = 4'h3;
   localparam logic [3:0] USE_FULL    = 4'hf;

   function automatic logic [3:0] epwm_pre_limit(input logic [1:0] sel);
      case (sel)
         2'h0:    epwm_pre_limit = PRE_DIV1;
         2'h1:    epwm_pre_limit = PRE_DIV4;
         default: epwm_pre_limit = PRE_DIV16;
      endcase
   endfunction

   function automatic logic epwm_addr_ok(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_CTRL, ADDR_DUTY, ADDR_PERIOD, ADDR_TCTRL,
         ADDR_FLAGS, ADDR_DIR, ADDR_TIMER: epwm_addr_ok = 1'b1;
         default:                          epwm_addr_ok = 1'b0;
      endcase
   endfunction

endpackage

// ===== epwm_sync.sv
`timescale 1ns/10ps
module epwm_sync (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= 1'b0;
         o_q    <= 1'b0;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule

// ===== epwm_top.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module epwm_top
   import epwm_pkg::*;
#(
   parameter int PER_W  = 8,
   parameter int DUTY_W = 10,
   parameter int PINS   = 4
) (
   input  wire logic              I_CLK,
   input  wire logic              I_RST,
   input  wire logic              I_SLEEP,
   input  wire logic [ADDR_W-1:0] I_AXI_AWADDR,
   input  wire logic              I_AXI_AWVALID,
   output logic                   O_AXI_AWREADY,
   input  wire logic [31:0]       I_AXI_WDATA,
   input  wire logic [3:0]        I_AXI_WSTRB,
   input  wire logic              I_AXI_WVALID,
   output logic                   O_AXI_WREADY,
   output logic [1:0]             O_AXI_BRESP,
   output logic                   O_AXI_BVALID,
   input  wire logic              I_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] I_AXI_ARADDR,
   input  wire logic              I_AXI_ARVALID,
   output logic                   O_AXI_ARREADY,
   output logic [31:0]            O_AXI_RDATA,
   output logic [1:0]             O_AXI_RRESP,
   output logic                   O_AXI_RVALID,
   input  wire logic              I_AXI_RREADY,
   output logic [PINS-1:0]        O_PWM_OUT,
   output logic [PINS-1:0]        O_PWM_OE_N
);

   if (PINS != 4 || PER_W < 2 || PER_W > 8 || DUTY_W != PER_W + 2) begin : g_chk
      $error("epwm_top: unsupported parameter set");
   end

   // ***********************************************************
   // declarations
   // ***********************************************************
   logic                slp_s;
   epwm_ctrl_t          ctrl_r,     ctrl_nxt;
   logic [PER_W-1:0]    duty_hi_r,  duty_hi_nxt;
   logic [PER_W-1:0]    period_r,   period_nxt;
   epwm_tctrl_t         tctrl_r,    tctrl_nxt;
   logic                flag_r,     flag_nxt;
   logic [PINS-1:0]     dir_r,      dir_nxt;
   logic                aw_got_r,   aw_got_nxt;
   logic                w_got_r,    w_got_nxt;
   logic [ADDR_W-1:0]   awaddr_r,   awaddr_nxt;
   logic [31:0]         wdata_r,    wdata_nxt;
   logic                wstrb_r,    wstrb_nxt;
   logic                aw_rdy_r,   aw_rdy_nxt;
   logic                w_rdy_r,    w_rdy_nxt;
   logic                bvalid_r,   bvalid_nxt;
   logic [1:0]          bresp_r,    bresp_nxt;
   logic                ar_rdy_r,   ar_rdy_nxt;
   logic                rvalid_r,   rvalid_nxt;
   logic [31:0]         rdata_r,    rdata_nxt;
   logic [1:0]          rresp_r,    rresp_nxt;
   logic [3:0]          pre_r,      pre_nxt;
   logic [1:0]          fine_r,     fine_nxt;
   logic [PER_W-1:0]    timer_r,    timer_nxt;
   logic [DUTY_W-1:0]   duty_q_r,   duty_q_nxt;
   logic                started_r,  started_nxt;
   logic [PINS-1:0]     out_r,      out_nxt;
   logic [PINS-1:0]     oe_n_r,     oe_n_nxt;
   logic                pwm_on;
   logic                tick;
   logic                wrap;
   logic                flag_set;
   logic                mod;
   logic [PINS-1:0]     act;
   logic [PINS-1:0]     used;
   logic [PINS-1:0]     pol;

   // ***********************************************************
   // sleep request synchroniser
   // ***********************************************************
   epwm_sync u_sync (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_d   (I_SLEEP),
      .o_q   (slp_s)
   );

   // ***********************************************************
   // pwm timebase and output stage
   // ***********************************************************
   always_comb begin
      pwm_on      = ctrl_r.msel_hi == MSEL_PWM;
      tick        = tctrl_r.run && !slp_s && pre_r == epwm_pre_limit(tctrl_r.pre);
      wrap        = tick && fine_r == FINE_LAST && timer_r == period_r;
      flag_set    = wrap && started_r;
      pre_nxt     = pre_r;
      fine_nxt    = fine_r;
      timer_nxt   = timer_r;
      duty_q_nxt  = duty_q_r;
      started_nxt = started_r;
      if (tctrl_r.run && !slp_s) begin
         pre_nxt = tick ? 4'h0 : pre_r + 4'h1;
      end
      if (tick) begin
         fine_nxt = fine_r + 2'h1;
         if (fine_r == FINE_LAST) begin
            timer_nxt = wrap ? '0 : timer_r + PER_W'(1);
         end
      end
      if (wrap) begin
         duty_q_nxt  = {duty_hi_r, ctrl_r.duty_lo};
         started_nxt = pwm_on;
      end
      if (!pwm_on && !slp_s) begin
         started_nxt = 1'b0;
      end
      mod = started_r && ({timer_r, fine_r} < duty_q_r);
      pol = {ctrl_r.pol_bd_low, ctrl_r.pol_ac_low,
             ctrl_r.pol_bd_low, ctrl_r.pol_ac_low};
      case (ctrl_r.cfg)
         EPWM_SINGLE: begin
            act  = {3'h0, mod};
            used = USE_SINGLE;
         end
         EPWM_HALF: begin
            act  = {2'h0, ~mod & started_r, mod};
            used = USE_HALF;
         end
         EPWM_FWD: begin
            act  = {mod, 2'h0, started_r};
            used = USE_FULL;
         end
         EPWM_REV: begin
            act  = {1'b0, started_r, mod, 1'b0};
            used = USE_FULL;
         end
         default: begin
            act  = '0;
            used = '0;
         end
      endcase
      out_nxt  = act ^ pol;
      oe_n_nxt = pwm_on ? ~(used & ~dir_r) : '1;
      if (slp_s) begin
         out_nxt  = out_r;
         oe_n_nxt = oe_n_r;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pre_r     <= '0;
         fine_r    <= '0;
         timer_r   <= '0;
         duty_q_r  <= '0;
         started_r <= 1'b0;
         out_r     <= '0;
         oe_n_r    <= '1;
      end else begin
         pre_r     <= pre_nxt;
         fine_r    <= fine_nxt;
         timer_r   <= timer_nxt;
         duty_q_r  <= duty_q_nxt;
         started_r <= started_nxt;
         out_r     <= out_nxt;
         oe_n_r    <= oe_n_nxt;
      end
   end

   // ***********************************************************
   // axi4-lite slave and register file
   // ***********************************************************
   always_comb begin
      ctrl_nxt    = ctrl_r;
      duty_hi_nxt = duty_hi_r;
      period_nxt  = period_r;
      tctrl_nxt   = tctrl_r;
      dir_nxt     = dir_r;
      flag_nxt    = flag_r | flag_set;
      aw_got_nxt  = aw_got_r;
      w_got_nxt   = w_got_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (I_AXI_AWVALID && aw_rdy_r) begin
         aw_got_nxt = 1'b1;
         awaddr_nxt = I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && w_rdy_r) begin
         w_got_nxt = 1'b1;
         wdata_nxt = I_AXI_WDATA;
         wstrb_nxt = I_AXI_WSTRB[0];
      end
      if (aw_got_r && w_got_r && !bvalid_r && !slp_s) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = epwm_addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         if (wstrb_r) begin
            case (awaddr_r)
               ADDR_CTRL:   ctrl_nxt    = epwm_ctrl_t'(wdata_r[7:0]);
               ADDR_DUTY:   duty_hi_nxt = wdata_r[PER_W-1:0];
               ADDR_PERIOD: period_nxt  = wdata_r[PER_W-1:0];
               ADDR_TCTRL:  tctrl_nxt   = epwm_tctrl_t'({5'h0, wdata_r[2:0]});
               ADDR_FLAGS:  flag_nxt    = flag_set | (flag_r & ~wdata_r[FLAG_BIT]);
               ADDR_DIR:    dir_nxt     = wdata_r[PINS-1:0];
               default:     ;
            endcase
         end
      end
      if (bvalid_r && I_AXI_BREADY) begin
         bvalid_nxt = 1'b0;
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
      end
      if (I_AXI_ARVALID && ar_rdy_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = epwm_addr_ok(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         case (I_AXI_ARADDR)
            ADDR_CTRL:   rdata_nxt = 32'(ctrl_r);
            ADDR_DUTY:   rdata_nxt = 32'(duty_hi_r);
            ADDR_PERIOD: rdata_nxt = 32'(period_r);
            ADDR_TCTRL:  rdata_nxt = 32'(tctrl_r);
            ADDR_FLAGS:  rdata_nxt = 32'(flag_r) << FLAG_BIT;
            ADDR_DIR:    rdata_nxt = 32'(dir_r);
            ADDR_TIMER:  rdata_nxt = 32'(timer_r);
            default:     rdata_nxt = 32'h0;
         endcase
      end
      if (rvalid_r && I_AXI_RREADY) begin
         rvalid_nxt = 1'b0;
      end
      aw_rdy_nxt = !aw_got_nxt;
      w_rdy_nxt  = !w_got_nxt;
      ar_rdy_nxt = !rvalid_nxt;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_r    <= epwm_ctrl_t'(CTRL_RST);
         duty_hi_r <= DUTY_RST[PER_W-1:0];
         period_r  <= PERIOD_RST[PER_W-1:0];
         tctrl_r   <= epwm_tctrl_t'(TCTRL_RST);
         flag_r    <= 1'b0;
         dir_r     <= DIR_RST;
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= 1'b0;
         aw_rdy_r  <= 1'b0;
         w_rdy_r   <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         ar_rdy_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         ctrl_r    <= ctrl_nxt;
         duty_hi_r <= duty_hi_nxt;
         period_r  <= period_nxt;
         tctrl_r   <= tctrl_nxt;
         flag_r    <= flag_nxt;
         dir_r     <= dir_nxt;
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         aw_rdy_r  <= aw_rdy_nxt;
         w_rdy_r   <= w_rdy_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         ar_rdy_r  <= ar_rdy_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   assign O_AXI_AWREADY = aw_rdy_r;
   assign O_AXI_WREADY  = w_rdy_r;
   assign O_AXI_BVALID  = bvalid_r;
   assign O_AXI_BRESP   = bresp_r;
   assign O_AXI_ARREADY = ar_rdy_r;
   assign O_AXI_RVALID  = rvalid_r;
   assign O_AXI_RDATA   = rdata_r;
   assign O_AXI_RRESP   = rresp_r;
   assign O_PWM_OUT     = out_r;
   assign O_PWM_OE_N    = oe_n_r;

   // ***********************************************************
   // checks
   // ***********************************************************
   AST_SLEEP_FREEZE: assert property (@(posedge I_CLK) disable iff (I_RST)
      slp_s |=> $stable(timer_r) && $stable(fine_r) && $stable(started_r))
      else $error("pwm state changed during sleep");
   AST_SLEEP_PINS: assert property (@(posedge I_CLK) disable iff (I_RST)
      slp_s |=> $stable(O_PWM_OUT) && $stable(O_PWM_OE_N))
      else $error("pin level changed during sleep");
   AST_RESUME: assert property (@(posedge I_CLK) disable iff (I_RST)
      $fell(slp_s) |-> timer_r == $past(timer_r))
      else $error("timer did not resume from held count");
   AST_WRAP: assert property (@(posedge I_CLK) disable iff (I_RST)
      wrap |=> timer_r == '0 && fine_r == 2'h0)
      else $error("period boundary did not restart timer");
   AST_HOLDOFF: assert property (@(posedge I_CLK) disable iff (I_RST)
      (!started_r && !slp_s) |=> O_PWM_OUT == $past(pol))
      else $error("waveform before first period boundary");
   AST_FLAG_SECOND: assert property (@(posedge I_CLK) disable iff (I_RST)
      $rose(flag_r) |-> $past(started_r) && $past(wrap))
      else $error("match flag set outside a completed period");
   AST_SINGLE_PINS: assert property (@(posedge I_CLK) disable iff (I_RST)
      (pwm_on && ctrl_r.cfg == EPWM_SINGLE && !slp_s) |=> O_PWM_OE_N[3:1] == 3'h7)
      else $error("single mode drove an unused pin");
   AST_HALF_COMP: assert property (@(posedge I_CLK) disable iff (I_RST)
      (started_r && ctrl_r.cfg == EPWM_HALF && !slp_s)
      |=> (O_PWM_OUT[0] ^ $past(pol[0])) != (O_PWM_OUT[1] ^ $past(pol[1])))
      else $error("half-bridge outputs not complementary");
   AST_HIZ: assert property (@(posedge I_CLK) disable iff (I_RST)
      (!pwm_on && !slp_s) |=> O_PWM_OE_N == '1)
      else $error("pin driven without pwm enabled");

endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
   import epwm_pkg::*;
   // ************************************************
   // signals
   // ************************************************
   logic              I_CLK;
   logic              I_RST;
   logic              I_SLEEP;
   logic [ADDR_W-1:0] I_AXI_AWADDR;
   logic              I_AXI_AWVALID;
   logic [31:0]       I_AXI_WDATA;
   logic [3:0]        I_AXI_WSTRB;
   logic              I_AXI_WVALID;
   logic              I_AXI_BREADY;
   logic [ADDR_W-1:0] I_AXI_ARADDR;
   logic              I_AXI_ARVALID;
   logic              I_AXI_RREADY;
   logic              O_AXI_AWREADY;
   logic              O_AXI_WREADY;
   logic [1:0]        O_AXI_BRESP;
   logic              O_AXI_BVALID;
   logic              O_AXI_ARREADY;
   logic [31:0]       O_AXI_RDATA;
   logic [1:0]        O_AXI_RRESP;
   logic              O_AXI_RVALID;
   logic [3:0]        O_PWM_OUT;
   logic [3:0]        O_PWM_OE_N;
   logic [3:0]        pin_level;
   int                mismatches = 0;
   int                n_tests = 0;
   int                cyc = 0;
   // high cycles of pins a..d in one 16-cycle period, duty 4
   localparam logic [4:0] EXP_CNT [4][4] = '{'{5'd4, 5'd0, 5'd0, 5'd0},
      '{5'd4, 5'd12, 5'd0, 5'd0}, '{5'd16, 5'd0, 5'd0, 5'd4}, '{5'd0, 5'd4, 5'd16, 5'd0}};
   localparam logic [3:0] EXP_USE [4] = '{USE_SINGLE, USE_HALF, USE_FULL, USE_FULL};
   localparam logic [7:0] RST_VAL [7] = '{CTRL_RST, DUTY_RST, PERIOD_RST, TCTRL_RST,
      8'h00, {4'h0, DIR_RST}, 8'h00};

   // ************************************************
   // design and load
   // ************************************************
   epwm_top u_epwm_top (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_SLEEP(I_SLEEP),
      .I_AXI_AWADDR(I_AXI_AWADDR), .I_AXI_AWVALID(I_AXI_AWVALID),
      .O_AXI_AWREADY(O_AXI_AWREADY), .I_AXI_WDATA(I_AXI_WDATA),
      .I_AXI_WSTRB(I_AXI_WSTRB), .I_AXI_WVALID(I_AXI_WVALID),
      .O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BRESP(O_AXI_BRESP),
      .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
      .I_AXI_ARADDR(I_AXI_ARADDR), .I_AXI_ARVALID(I_AXI_ARVALID),
      .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA),
      .O_AXI_RRESP(O_AXI_RRESP), .O_AXI_RVALID(O_AXI_RVALID),
      .I_AXI_RREADY(I_AXI_RREADY), .O_PWM_OUT(O_PWM_OUT), .O_PWM_OE_N(O_PWM_OE_N));
   epwm_load u_epwm_load (.i_pwm_out(O_PWM_OUT), .i_pwm_oe_n(O_PWM_OE_N), .o_level(pin_level));

   always #5 I_CLK = ~I_CLK;
   always @(posedge I_CLK) cyc <= cyc + 1;

   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wre(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
      I_AXI_AWADDR  <= a;
      I_AXI_WDATA   <= {24'h0, d};
      I_AXI_AWVALID <= 1'b1;
      I_AXI_WVALID  <= 1'b1;
      I_AXI_BREADY  <= 1'b1;
      forever begin
         @(posedge I_CLK);
         if (O_AXI_AWREADY) I_AXI_AWVALID <= 1'b0;
         if (O_AXI_WREADY) I_AXI_WVALID <= 1'b0;
         if (O_AXI_BVALID) begin
            I_AXI_BREADY <= 1'b0;
            chk({30'h0, O_AXI_BRESP}, {30'h0, er});
            break;
         end
      end
      @(posedge I_CLK);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      wre(a, d, RESP_OKAY);
   endtask

   task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
      I_AXI_ARADDR  <= a;
      I_AXI_ARVALID <= 1'b1;
      I_AXI_RREADY  <= 1'b1;
      forever begin
         @(posedge I_CLK);
         if (O_AXI_ARREADY) I_AXI_ARVALID <= 1'b0;
         if (O_AXI_RVALID) begin
            I_AXI_RREADY <= 1'b0;
            d = O_AXI_RDATA;
            chk({30'h0, O_AXI_RRESP}, {30'h0, er});
            break;
         end
      end
      @(posedge I_CLK);
   endtask

   function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] lo,
                                      input logic [1:0] pol);
      return {m, lo, MSEL_PWM, pol};
   endfunction

   // drivers off while the mode changes, 40 clocks, then drivers on
   task automatic setmode(input logic [7:0] c);
      wr(ADDR_DIR, 8'h0f);
      wr(ADDR_CTRL, c);
      repeat (40) @(posedge I_CLK);
      wr(ADDR_DIR, 8'h00);
      @(negedge I_CLK);
   endtask

   task automatic measure(input logic [4:0] e [4]);
      logic [4:0] c [4];
      c = '{default: 5'd0};
      repeat (16) begin
         @(negedge I_CLK);
         for (int i = 0; i < 4; i++) c[i] = c[i] + {4'h0, pin_level[i]};
      end
      for (int i = 0; i < 4; i++) chk({27'h0, c[i]}, {27'h0, e[i]});
      @(posedge I_CLK);
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset;
      logic [31:0] d;
      chk({28'h0, O_PWM_OE_N}, 32'hf);
      // timer count is read only, a write without byte 0 strobe is ignored
      wr(ADDR_TIMER, 8'h55);
      I_AXI_WSTRB <= 4'h0;
      wr(ADDR_DUTY, 8'h55);
      I_AXI_WSTRB <= 4'h1;
      for (int i = 0; i < 7; i++) begin
         rd(5'(i * 4), RESP_OKAY, d);
         chk(d, {24'h0, RST_VAL[i]});
      end
      rd(5'h1c, RESP_SLVERR, d);
      chk(d, 32'h0);
      wre(5'h1c, 8'h55, RESP_SLVERR);
   endtask

   task automatic t_startup;
      logic [31:0] d;
      logic        bad;
      int          t0;
      wr(ADDR_DIR, 8'h0f);
      wr(ADDR_PERIOD, 8'h03);
      wr(ADDR_CTRL, ctl(EPWM_SINGLE, 2'b00, 2'b00));
      wr(ADDR_DUTY, 8'h01);
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_TCTRL, 8'h04);
      t0 = cyc;
      bad = 1'b0;
      repeat (10) begin
         @(posedge I_CLK);
         bad = bad | (O_PWM_OUT !== 4'h0);
      end
      chk({31'h0, bad}, 32'h0);
      d = 32'h0;
      while (d[FLAG_BIT] !== 1'b1) rd(ADDR_FLAGS, RESP_OKAY, d);
      chk({31'h0, (cyc - t0 >= 24) && (cyc - t0 <= 40)}, 32'h1);
      chk({28'h0, O_PWM_OE_N}, 32'hf);
      wr(ADDR_DIR, 8'h00);
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         setmode(ctl(m[1:0], 2'b00, 2'b00));
         chk({28'h0, O_PWM_OE_N}, {28'h0, ~EXP_USE[m]});
         measure(EXP_CNT[m]);
      end
      setmode(ctl(EPWM_FWD, 2'b00, 2'b11));
      measure('{5'd0, 5'd16, 5'd16, 5'd12});
      setmode(ctl(EPWM_SINGLE, 2'b10, 2'b00));
      measure('{5'd6, 5'd0, 5'd0, 5'd0});
   endtask

   task automatic t_sleep;
      logic [31:0] t1;
      logic [31:0] t2;
      logic [3:0]  o;
      logic [3:0]  e;
      logic        bad;
      wr(ADDR_PERIOD, 8'hff);
      wr(ADDR_TCTRL, 8'h06);
      repeat (200) @(posedge I_CLK);
      I_SLEEP <= 1'b1;
      repeat (4) @(posedge I_CLK);
      o = O_PWM_OUT;
      e = O_PWM_OE_N;
      rd(ADDR_TIMER, RESP_OKAY, t1);
      bad = 1'b0;
      repeat (40) begin
         @(posedge I_CLK);
         bad = bad | (O_PWM_OUT !== o) | (O_PWM_OE_N !== e);
      end
      chk({31'h0, bad}, 32'h0);
      rd(ADDR_TIMER, RESP_OKAY, t2);
      chk(t2, t1);
      I_SLEEP <= 1'b0;
      repeat (70) @(posedge I_CLK);
      rd(ADDR_TIMER, RESP_OKAY, t2);
      chk({31'h0, (t2 == t1 + 1) || (t2 == t1 + 2)}, 32'h1);
      // prescale /4: one timer step every 16 clocks, 67 clocks between samples
      wr(ADDR_TCTRL, 8'h05);
      repeat (20) @(posedge I_CLK);
      rd(ADDR_TIMER, RESP_OKAY, t1);
      repeat (64) @(posedge I_CLK);
      rd(ADDR_TIMER, RESP_OKAY, t2);
      chk({31'h0, (t2 == t1 + 4) || (t2 == t1 + 5)}, 32'h1);
   endtask

   task automatic t_rereset;
      I_RST <= 1'b1;
      @(negedge I_CLK);
      chk({28'h0, O_PWM_OE_N}, 32'hf);
      repeat (4) @(posedge I_CLK);
      I_RST <= 1'b0;
      @(posedge I_CLK);
      t_reset();
   endtask

   task automatic end_of_test;
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ************************************************
   // main sequence and watchdog
   // ************************************************
   initial begin
      I_CLK = 1'b0;
      I_RST = 1'b1;
      I_SLEEP = 1'b0;
      I_AXI_AWADDR = '0;
      I_AXI_AWVALID = 1'b0;
      I_AXI_WDATA = 32'h0;
      I_AXI_WSTRB = 4'h1;
      I_AXI_WVALID = 1'b0;
      I_AXI_BREADY = 1'b0;
      I_AXI_ARADDR = '0;
      I_AXI_ARVALID = 1'b0;
      I_AXI_RREADY = 1'b0;
      repeat (4) @(posedge I_CLK);
      I_RST <= 1'b0;
      @(posedge I_CLK);
      t_reset();
      t_startup();
      t_modes();
      t_sleep();
      t_rereset();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge I_CLK);
      mismatches++;
      end_of_test();
   end
endmodule
